// File: rtl/tsao_top.sv
// t1 signaling inserter with trouble, power-fail and transfer outputs
//
// Overview of operation
// R1: robbed-bit mode replaces channel lsb with signaling in every sixth frame
// R2: common-channel mode packs channel 1-23 signaling into channel 24 word
// R3: common-channel mode never passes payload in channel 24
// R4: mode select applies to t1 only; isdn primary rate forces common-channel
// R5: robbed-bit channels are voice only, never flagged clear for data
// R6: clear 64k data only with isdn, esf, common-channel and b8zs together
// R7: software should pick robbed-bit for voice-only links, esf in general
// R8: detected malfunction closes contacts of the port set as trouble alarm
// R9: power failure closes contacts of the port set as power-fail alarm
// R10: power failure shorts the busy-out pair of a busy-out port
// R11: transfer jack idle normally, connects its line only on power loss
// R12: software must not put a transfer phone on a power-fail alarm port
// R13: frame counter wraps modulo six, aligned to the superframe
`timescale 1ns/1ps
`default_nettype none
module tsao_top (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             irq,
   // outgoing channel stream, same clock
   input  wire logic        in_valid,
   input  wire logic [7:0]  in_data,
   input  wire logic        frame_start,
   input  wire logic        superframe_start,
   output logic             out_valid,
   output logic      [7:0]  out_data,
   output logic             out_frame_start,
   output logic             out_clear_ok,
   // alarm pins, asynchronous
   input  wire logic        trouble_in,
   input  wire logic        power_fail_in,
   output logic             trouble_contact,
   output logic             pf_alarm_contact,
   output logic             busy_out_short,
   output logic             transfer_connect
);
   typedef struct packed {
      logic [tsao_pkg::CTRL_W-1:0] ctrl;
      logic [23:0]                 sig;
      logic [tsao_pkg::PORT_W-1:0] port;
      logic [tsao_pkg::EVT_W-1:0]  sts;
      logic [tsao_pkg::EVT_W-1:0]  ien;
      logic [31:0]                 rdata;
      logic [4:0]                  chan;
      logic [2:0]                  frame;
      logic                        ovalid;
      logic [7:0]                  odata;
      logic                        ofirst;
      logic                        oclear;
      logic                        trbl_c;
      logic                        pfa_c;
      logic                        busy_c;
      logic                        xfer_c;
      logic                        trbl_q;
      logic                        pf_q;
   } tsao_state_type;

   tsao_state_type st_ff;
   tsao_state_type nxt_st;

   logic [1:0] pins_sync;
   logic       trouble_s;
   logic       pwr_fail_s;
   logic       eff_ccs;
   logic       trouble_now;
   logic       clear_cfg;
   logic [4:0] cur_chan;
   logic [2:0] cur_frame;
   logic       is_rob_slot;
   logic       is_ccs_slot;
   logic [7:0] ccs_word;
   logic [2:0] evt_set;
   logic [2:0] evt_clr;

   // effective mode: isdn overrides the t1 selection
   function automatic logic ccs_active(input logic [4:0] c);
      ccs_active = c[tsao_pkg::CTRL_ISDN_PRI] | c[tsao_pkg::CTRL_CCS_SEL];
   endfunction

   // which octet of the 23 signaling bits rides in this frame
   function automatic logic [7:0] ccs_octet(input logic [23:0] s,
                                            input logic [2:0]  f);
      logic [23:0] m;
      m = s & tsao_pkg::CCS_MASK;
      case (f)
         3'h0, 3'h3: ccs_octet = m[7:0];
         3'h1, 3'h4: ccs_octet = m[15:8];
         default:    ccs_octet = m[23:16];
      endcase
   endfunction

   tsao_sync2 u_sync (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .async_in ({power_fail_in, trouble_in}),
      .sync_out (pins_sync)
   );
   assign trouble_s  = pins_sync[0];
   assign pwr_fail_s = pins_sync[1];

   // per-byte position and mode decode
   always_comb begin
      eff_ccs     = ccs_active(st_ff.ctrl); // R4
      trouble_now = trouble_s | st_ff.ctrl[tsao_pkg::CTRL_SW_TRBL];
      clear_cfg   = st_ff.ctrl[tsao_pkg::CTRL_ISDN_PRI]
                  & st_ff.ctrl[tsao_pkg::CTRL_ESF]
                  & st_ff.ctrl[tsao_pkg::CTRL_B8ZS]
                  & eff_ccs; // R6
      cur_chan    = frame_start ? 5'h00 : st_ff.chan;
      if (!frame_start) begin
         cur_frame = st_ff.frame;
      end else if (superframe_start) begin
         cur_frame = 3'h0; // R13
      end else if (st_ff.frame == tsao_pkg::LAST_FRAME) begin
         cur_frame = 3'h0; // R13
      end else begin
         cur_frame = st_ff.frame + 3'h1;
      end
      is_rob_slot = !eff_ccs && (cur_frame == tsao_pkg::ROB_FRAME);
      is_ccs_slot = eff_ccs && (cur_chan == tsao_pkg::LAST_CHAN);
      ccs_word    = ccs_octet(st_ff.sig, cur_frame);
   end

   // event sources and software clears
   always_comb begin
      evt_set = 3'h0;
      evt_set[tsao_pkg::EVT_TROUBLE]  = trouble_now & ~st_ff.trbl_q;
      evt_set[tsao_pkg::EVT_PWR_FAIL] = pwr_fail_s & ~st_ff.pf_q;
      evt_set[tsao_pkg::EVT_SUPERFRM] = in_valid & frame_start
                                      & superframe_start;
      evt_clr = (reg_wr && reg_addr == tsao_pkg::ADDR_IRQ_CLR)
              ? reg_wdata[tsao_pkg::EVT_W-1:0] : 3'h0;
   end

   // next-state logic of the whole block
   always_comb begin
      nxt_st = st_ff;
      // register writes
      if (reg_wr) begin
         case (reg_addr)
            tsao_pkg::ADDR_CTRL:
               nxt_st.ctrl = reg_wdata[tsao_pkg::CTRL_W-1:0];
            tsao_pkg::ADDR_SIG:    nxt_st.sig = reg_wdata[23:0];
            tsao_pkg::ADDR_PORT:
               nxt_st.port = reg_wdata[tsao_pkg::PORT_W-1:0];
            tsao_pkg::ADDR_IRQ_EN:
               nxt_st.ien = reg_wdata[tsao_pkg::EVT_W-1:0];
            default: nxt_st.ien = st_ff.ien;
         endcase
      end
      // sticky status, a new event beats a clear
      nxt_st.sts = (st_ff.sts & ~evt_clr) | evt_set;
      // read data for the next cycle only, zero when unmapped
      nxt_st.rdata = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            tsao_pkg::ADDR_CTRL:   nxt_st.rdata = {27'h0, st_ff.ctrl};
            tsao_pkg::ADDR_SIG:    nxt_st.rdata = {8'h00, st_ff.sig};
            tsao_pkg::ADDR_PORT:   nxt_st.rdata = {29'h0, st_ff.port};
            tsao_pkg::ADDR_STATUS: nxt_st.rdata = {29'h0, st_ff.sts};
            tsao_pkg::ADDR_IRQ_EN: nxt_st.rdata = {29'h0, st_ff.ien};
            tsao_pkg::ADDR_STATE:
               nxt_st.rdata = {18'h00000, st_ff.trbl_c, st_ff.pfa_c,
                               st_ff.busy_c, st_ff.xfer_c, clear_cfg,
                               eff_ccs, st_ff.frame, st_ff.chan};
            default: nxt_st.rdata = 32'h00000000;
         endcase
      end
      // stream: one-cycle registered path
      nxt_st.ovalid = in_valid;
      if (in_valid) begin
         nxt_st.ofirst = frame_start;
         nxt_st.frame  = cur_frame;
         nxt_st.chan   = (cur_chan == tsao_pkg::LAST_CHAN)
                       ? 5'h00 : cur_chan + 5'h01;
         if (is_ccs_slot) begin
            nxt_st.odata  = ccs_word; // R2 R3
            nxt_st.oclear = 1'b0;
         end else if (is_rob_slot) begin
            nxt_st.odata  = {in_data[7:1], st_ff.sig[cur_chan]}; // R1
            nxt_st.oclear = 1'b0; // R5
         end else begin
            nxt_st.odata  = in_data;
            nxt_st.oclear = clear_cfg; // R5 R6
         end
      end else begin
         nxt_st.ofirst = 1'b0;
         nxt_st.oclear = 1'b0;
      end
      // alarm contacts follow the programmed port function
      nxt_st.trbl_q = trouble_now;
      nxt_st.pf_q   = pwr_fail_s;
      nxt_st.trbl_c = trouble_now
                    && st_ff.port[1:0] == tsao_pkg::FUNC_TROUBLE; // R8
      nxt_st.pfa_c  = pwr_fail_s
                    && st_ff.port[1:0] == tsao_pkg::FUNC_PF_ALM; // R9
      nxt_st.busy_c = pwr_fail_s
                    && st_ff.port[1:0] == tsao_pkg::FUNC_BUSYOUT; // R10
      // a misconfigured alarm port keeps its phone cut off
      nxt_st.xfer_c = pwr_fail_s
                    && st_ff.port[tsao_pkg::PORT_XFER_EN]
                    && st_ff.port[1:0] != tsao_pkg::FUNC_PF_ALM; // R11 R12
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_ff        <= '0;
         st_ff.ctrl   <= tsao_pkg::CTRL_RESET;
         st_ff.sig    <= tsao_pkg::SIG_RESET;
         st_ff.port   <= tsao_pkg::PORT_RESET;
         st_ff.sts    <= tsao_pkg::EVT_RESET;
         st_ff.ien    <= tsao_pkg::EVT_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from flops; irq ors status flops masked by enables
   assign reg_rdata        = st_ff.rdata;
   assign irq              = |(st_ff.sts & st_ff.ien);
   assign out_valid        = st_ff.ovalid;
   assign out_data         = st_ff.odata;
   assign out_frame_start  = st_ff.ofirst;
   assign out_clear_ok     = st_ff.oclear;
   assign trouble_contact  = st_ff.trbl_c;
   assign pf_alarm_contact = st_ff.pfa_c;
   assign busy_out_short   = st_ff.busy_c;
   assign transfer_connect = st_ff.xfer_c;

   // checks on the design's own outputs and internal state
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   property p_rob_lsb;
      in_valid && !eff_ccs && cur_frame == 3'h5
      |=> out_data[0] == $past(st_ff.sig[cur_chan]);
   endproperty
   a_rob_lsb: assert property (p_rob_lsb) // R1
      else $error("robbed bit not inserted");

   property p_rob_upper;
      in_valid && !is_ccs_slot |=> out_data[7:1] == $past(in_data[7:1]);
   endproperty
   a_rob_upper: assert property (p_rob_upper) // R1
      else $error("payload upper bits altered");

   property p_ccs_slot;
      in_valid && eff_ccs && cur_chan == 5'h17
      |=> out_data == $past(ccs_word) && !out_clear_ok;
   endproperty
   a_ccs_slot: assert property (p_ccs_slot) // R2
      else $error("channel 24 not carrying signaling");

   property p_ccs_no_payload;
      in_valid && eff_ccs && cur_chan == 5'h17 && in_data != ccs_word
      |=> out_data != $past(in_data);
   endproperty
   a_ccs_no_payload: assert property (p_ccs_no_payload) // R3
      else $error("payload leaked into channel 24");

   property p_isdn_ccs;
      st_ff.ctrl[1] |-> eff_ccs;
   endproperty
   a_isdn_ccs: assert property (p_isdn_ccs) // R4
      else $error("isdn not forcing common channel");

   property p_rob_no_clear;
      in_valid && !eff_ccs |=> !out_clear_ok;
   endproperty
   a_rob_no_clear: assert property (p_rob_no_clear) // R5
      else $error("robbed channel flagged clear");

   property p_clear_cfg;
      out_clear_ok |-> $past(clear_cfg);
   endproperty
   a_clear_cfg: assert property (p_clear_cfg) // R6
      else $error("clear data without full config");

   property p_trouble;
      trouble_now && st_ff.port[1:0] == tsao_pkg::FUNC_TROUBLE
      |=> trouble_contact;
   endproperty
   a_trouble: assert property (p_trouble) // R8
      else $error("trouble contact not closed");

   property p_trouble_contact;
      trouble_contact |-> $past(trouble_now);
   endproperty
   a_trouble_contact: assert property (p_trouble_contact) // R8
      else $error("trouble contact without malfunction");

   property p_pf_alarm;
      pwr_fail_s && st_ff.port[1:0] == 2'h2 |=> pf_alarm_contact;
   endproperty
   a_pf_alarm: assert property (p_pf_alarm) // R9
      else $error("power fail alarm contact open");

   property p_busy;
      busy_out_short == $past(pwr_fail_s && st_ff.port[1:0] == 2'h3);
   endproperty
   a_busy: assert property (p_busy) // R10
      else $error("busy-out pair wrong");

   property p_xfer;
      transfer_connect |-> $past(pwr_fail_s) && !pf_alarm_contact;
   endproperty
   a_xfer: assert property (p_xfer) // R11
      else $error("transfer active without power loss");

   property p_frame_wrap;
      in_valid && frame_start && !superframe_start && st_ff.frame == 3'h5
      |=> st_ff.frame == 3'h0;
   endproperty
   a_frame_wrap: assert property (p_frame_wrap) // R13
      else $error("frame counter not wrapping at six");

   property p_frame_range;
      st_ff.frame <= 3'h5;
   endproperty
   a_frame_range: assert property (p_frame_range) // R13
      else $error("frame counter out of range");
endmodule
`default_nettype wire

// File: rtl/tsao_pkg.sv
// constants, register map and field layout of the t1 signaling and alarm block
package tsao_pkg;
   // register word addresses
   localparam logic [3:0] ADDR_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_SIG     = 4'h1;
   localparam logic [3:0] ADDR_PORT    = 4'h2;
   localparam logic [3:0] ADDR_STATUS  = 4'h3;
   localparam logic [3:0] ADDR_IRQ_EN  = 4'h4;
   localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
   localparam logic [3:0] ADDR_STATE   = 4'h6;
   // control register fields
   localparam int CTRL_W        = 5;
   localparam int CTRL_CCS_SEL  = 0;
   localparam int CTRL_ISDN_PRI = 1;
   localparam int CTRL_ESF      = 2;
   localparam int CTRL_B8ZS     = 3;
   localparam int CTRL_SW_TRBL  = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // port configuration fields
   localparam int PORT_W        = 3;
   localparam int PORT_XFER_EN  = 2;
   localparam logic [2:0] PORT_RESET = 3'h0;
   localparam logic [1:0] FUNC_NONE    = 2'h0;
   localparam logic [1:0] FUNC_TROUBLE = 2'h1;
   localparam logic [1:0] FUNC_PF_ALM  = 2'h2;
   localparam logic [1:0] FUNC_BUSYOUT = 2'h3;
   // status, enable and clear share this layout
   localparam int EVT_W         = 3;
   localparam int EVT_TROUBLE   = 0;
   localparam int EVT_PWR_FAIL  = 1;
   localparam int EVT_SUPERFRM  = 2;
   localparam logic [2:0] EVT_RESET = 3'h0;
   // frame structure
   localparam int CHANS         = 24;
   localparam logic [4:0] LAST_CHAN  = 5'h17;
   localparam logic [2:0] LAST_FRAME = 3'h5;
   localparam logic [2:0] ROB_FRAME  = 3'h5;
   localparam logic [23:0] SIG_RESET = 24'h000000;
   localparam logic [23:0] CCS_MASK  = 24'h7FFFFF;
   // synchroniser reset level of the alarm pins
   localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage

// File: rtl/tsao_sync2.sv
// two flip-flop synchroniser for the asynchronous alarm pins
`timescale 1ns/1ps
`default_nettype none
module tsao_sync2 (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic [1:0] async_in,
   output logic      [1:0] sync_out
);
   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] stable;
   } tsao_sync_type;

   tsao_sync_type st_ff;
   tsao_sync_type nxt_st;

   // first stage feeds only the second stage
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.meta   = async_in;
      nxt_st.stable = st_ff.meta;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_ff <= '{meta: tsao_pkg::SYNC_RESET, stable: tsao_pkg::SYNC_RESET};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.stable;
endmodule
`default_nettype wire

// File: bench/tsao_net_model.sv
// far-end network sink: checks 24 octets between frame marks
`timescale 1ns/1ps
`default_nettype none
module tsao_net_model (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic rx_valid,
   input  wire logic rx_frame_start,
   output logic      frame_err
);
   logic [4:0] chan_ff;
   // a frame mark before 24 octets, or a 25th octet, latches an error
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         chan_ff   <= 5'h00;
         frame_err <= 1'h0;
      end else if (rx_valid) begin
         if (rx_frame_start) begin
            if (chan_ff != 5'h18 && chan_ff != 5'h00) frame_err <= 1'h1;
            chan_ff <= 5'h01;
         end else begin
            if (chan_ff >= 5'h18) frame_err <= 1'h1;
            chan_ff <= chan_ff + 5'h01;
         end
      end
   end
endmodule
`default_nettype wire

// File: bench/tsao_top_tb.sv
// self-checking bench: stream, alarm pins and registers of tsao_top
`timescale 1ns/1ps
`default_nettype none
module tsao_top_tb;
   logic        ref_clk, reset, reg_wr, reg_rd, irq, in_valid;
   logic        frame_start, superframe_start, out_valid, out_frame_start;
   logic        out_clear_ok, trouble_in, power_fail_in, trouble_contact;
   logic        pf_alarm_contact, busy_out_short, transfer_connect;
   logic        frame_err, rd_pend;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [7:0]  in_data, d, out_data;
   logic [4:0]  cur_ctrl;
   logic [23:0] cur_sig;
   logic [31:0] rd_q[$];
   logic [8:0]  st_q[$];
   logic [4:0]  ctrl_tab[5] = '{5'h00, 5'h01, 5'h0E, 5'h0D, 5'h0A};
   int          seed = 24470;
   int          bad_count, comparisons, cycles, fr;
   tsao_top tsao_top_i (.ref_clk(ref_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .in_valid(in_valid), .in_data(in_data), .frame_start(frame_start),
      .superframe_start(superframe_start), .out_valid(out_valid),
      .out_data(out_data), .out_frame_start(out_frame_start),
      .out_clear_ok(out_clear_ok), .trouble_in(trouble_in),
      .power_fail_in(power_fail_in), .trouble_contact(trouble_contact),
      .pf_alarm_contact(pf_alarm_contact), .busy_out_short(busy_out_short),
      .transfer_connect(transfer_connect));
   tsao_net_model tsao_net_model_i (.ref_clk(ref_clk), .reset(reset),
      .rx_valid(out_valid), .rx_frame_start(out_frame_start),
      .frame_err(frame_err));
   // 200 MHz clock
   initial begin
      ref_clk = 1'h0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] v);
      @(posedge ref_clk);
      reg_wr    <= 1'h1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] v);
      @(posedge ref_clk);
      reg_rd   <= 1'h1;
      reg_addr <= a;
      rd_q.push_back(v);
      @(posedge ref_clk);
      reg_rd <= 1'h0;
   endtask
   task automatic settle(int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   // expected octet and clear flag, top bit is the clear flag
   function automatic logic [8:0] exp_byte(int ch, logic [7:0] v);
      logic       common_channel_mode;
      logic [23:0] s;
      logic [7:0] o;
      common_channel_mode = cur_ctrl[0] | cur_ctrl[1];
      s = cur_sig & tsao_pkg::CCS_MASK;
      o = v;
      if (common_channel_mode && ch == 23) o = s[8*(fr%3) +: 8];
      else if (!common_channel_mode && fr == 5) o = {v[7:1], cur_sig[ch]};
      return {cur_ctrl[1] & cur_ctrl[2] & cur_ctrl[3] & common_channel_mode & (ch != 23), o};
   endfunction
   // one frame of 24 random octets, expectations noted as they go out
   task automatic send_frame(logic sf);
      fr = sf ? 0 : (fr == 5 ? 0 : fr + 1);
      for (int ch = 0; ch < tsao_pkg::CHANS; ch++) begin
         @(posedge ref_clk);
         d = 8'($random(seed));
         in_valid <= 1'h1; in_data <= d;
         frame_start <= (ch == 0); superframe_start <= sf && ch == 0;
         st_q.push_back(exp_byte(ch, d));
      end
      @(posedge ref_clk);
      in_valid <= 1'h0; frame_start <= 1'h0; superframe_start <= 1'h0;
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge ref_clk) rd_pend <= reg_rd;
   always @(negedge ref_clk) begin
      if (rd_pend === 1'h1 && rd_q.size() > 0) begin
         check("reg_rdata", reg_rdata, rd_q.pop_front());
      end
      if (out_valid === 1'h1 && st_q.size() > 0) begin
         check("out_data", out_data, 32'(st_q[0][7:0]));
         check("out_clear_ok", out_clear_ok, st_q[0][8]);
         void'(st_q.pop_front());
      end
   end
   // hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 10000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      reset = 1'h1; reg_wr = 1'h0; reg_rd = 1'h0; reg_addr = 4'h0;
      reg_wdata = 32'h00000000; in_valid = 1'h0; in_data = 8'h00;
      frame_start = 1'h0; superframe_start = 1'h0; trouble_in = 1'h0;
      power_fail_in = 1'h0;
      repeat (2) @(posedge ref_clk);
      reset <= 1'h0;
      // reset values, unmapped address reads zero
      for (int a = 0; a < 6; a++) rd(a[3:0], 32'h00000000);
      rd(4'h7, 32'h00000000);
      // five control settings from ctrl_tab, wrap of the frame count and realignment
      for (int m = 0; m < 5; m++) begin
         cur_ctrl = ctrl_tab[m];
         cur_sig = 24'($random(seed));
         wr(tsao_pkg::ADDR_CTRL, {27'h0000000, cur_ctrl});
         wr(tsao_pkg::ADDR_SIG, {8'h00, cur_sig});
         for (int k = 0; k < 9; k++) send_frame(k == 0 || k == 7);
      end
      settle(3);
      check("frame_err", frame_err, 1'h0);
      // only the superframe event is pending; isdn forces ccs, frame 1
      rd(tsao_pkg::ADDR_STATUS, 32'h4);
      rd(tsao_pkg::ADDR_STATE, 32'h120);
      // every port function with and without a transfer phone
      for (int p = 0; p < 8; p++) begin
         wr(tsao_pkg::ADDR_PORT, p);
         trouble_in <= 1'h1; power_fail_in <= 1'h1;
         settle(5);
         check("trouble_contact", trouble_contact, p[1:0] == 2'h1);
         check("pf_alarm_contact", pf_alarm_contact, p[1:0] == 2'h2);
         check("busy_out_short", busy_out_short, p[1:0] == 2'h3);
         check("xfer", transfer_connect, p[2] && p[1:0] != 2'h2);
         trouble_in <= 1'h0; power_fail_in <= 1'h0;
         settle(5);
         check("idle_trouble", trouble_contact, 1'h0);
         check("idle_pf_alarm", pf_alarm_contact, 1'h0);
         check("idle_busy_out", busy_out_short, 1'h0);
         check("idle_xfer", transfer_connect, 1'h0);
      end
      // software trouble bit closes a trouble port as a pin would
      wr(tsao_pkg::ADDR_PORT, 32'h1);
      wr(tsao_pkg::ADDR_CTRL, 32'h10);
      settle(2);
      check("sw_trouble", trouble_contact, 1'h1);
      rd(tsao_pkg::ADDR_STATUS, 32'h7);
      wr(tsao_pkg::ADDR_CTRL, 32'h0);
      settle(2);
      check("sw_trouble", trouble_contact, 1'h0);
      // sticky status, mask, clear and read-only write
      wr(tsao_pkg::ADDR_IRQ_CLR, 32'h7);
      rd(tsao_pkg::ADDR_STATUS, 32'h0);
      wr(tsao_pkg::ADDR_STATUS, 32'h7);
      rd(tsao_pkg::ADDR_STATUS, 32'h0);
      wr(tsao_pkg::ADDR_IRQ_EN, 32'h2);
      power_fail_in <= 1'h1;
      settle(5);
      rd(tsao_pkg::ADDR_STATUS, 32'h2);
      settle(0);
      check("irq", irq, 1'h1);
      wr(tsao_pkg::ADDR_IRQ_EN, 32'h0);
      settle(1);
      check("irq", irq, 1'h0);
      wr(tsao_pkg::ADDR_IRQ_EN, 32'h2);
      power_fail_in <= 1'h0;
      settle(5);
      check("irq", irq, 1'h1);
      wr(tsao_pkg::ADDR_IRQ_CLR, 32'h2);
      settle(1);
      check("irq", irq, 1'h0);
      rd(tsao_pkg::ADDR_IRQ_EN, 32'h2);
      settle(3);
      give_verdict();
   end
endmodule
`default_nettype wire
